// ### cpt_panel_model.sv
// coder panel model: coder clock, frame strobe, compander reset
`timescale 1ns/100ps
module cpt_panel_model (
	// clock
	input  wire logic clk,
	// commands from bench
	input  wire logic frame_req,
	input  wire logic creset_req,
	// to block
	output logic      coder_clk = 1'b0,
	output logic      frame_stb = 1'b0,
	output logic      creset    = 1'b0
);
	logic [4:0] cnt_q = 5'h00;

	always_ff @(posedge clk) begin
		cnt_q <= (cnt_q == 5'h15) ? 5'h00 : cnt_q + 5'h01;
		coder_clk <= (cnt_q < 5'h05);
		if (cnt_q == 5'h0B) begin
			frame_stb <= frame_req;
			creset <= creset_req;
		end
	end
endmodule : cpt_panel_model

// ### cpt_pkg.sv
// package: constants and types for the coder phase timing generator
package cpt_pkg;
	// reference clock period and decision strobe delay
	localparam int          CLK_PERIOD_NS   = 20;
	localparam real         DEC_DELAY_US    = 0.1;
	localparam int          DEC_DELAY_NS    = int'(DEC_DELAY_US * 1000.0);
	localparam int          DEC_DELAY_CYC   = (DEC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// chain layout
	localparam int          STAGES          = 6;
	localparam int          ST_PHASE_TWO    = 0;
	localparam int          ST_PHASE_THREE  = 1;
	localparam int          ST_PHASE_FOUR   = 2;
	localparam int          ST_PHASE_FIVE   = 3;
	localparam int          ST_PHASE_SIX    = 4;
	localparam int          ST_PHASE_ONE    = 5;
	// reset values
	localparam logic [5:0]  STAGE_RST       = 6'h00;
	localparam logic        COMP_RST        = 1'h1;
	localparam logic        DEC_RST         = 1'h1;
	localparam logic        SIX_INV_RST     = 1'h1;

	typedef struct packed {
		logic [1:0]               clk_sync;
		logic [1:0]               frame_sync;
		logic [1:0]               creset_sync;
		logic                     clk_prev;
		logic [DEC_DELAY_CYC-1:0] dly;
		logic [STAGES-1:0]        stage;
		logic                     six_inv;
		logic                     comp;
		logic                     comp_n;
		logic                     dec;
	} cpt_state_t;
endpackage : cpt_pkg

// ### cpt_timing_gen.sv
// module: coder phase timing generator, one reference clock domain
`timescale 1ns/100ps
// Contract
// - decision strobe is inverted clock, delayed 0.1us
// - frame strobe gated with coder clock
// - first stage sets on gated frame strobe
// - active stage clears at next coder clock
// - second stage follows first each clock
// - four more stages give phases four..one
// - inverted phase six output and sets compander
// - compander reset plus clock selects attenuator
// - inverted phase six sets amplifier state
// - compander state output as complementary pair
// - all pulses and controls go to panel
module cpt_timing_gen (
	// clock and reset
	input  wire logic REF_CLK,
	input  wire logic RST,
	// from coder panel
	input  wire logic CODER_CLK,
	input  wire logic FRAME_PHASE_STROBE,
	input  wire logic COMPANDER_RESET,
	// to coder panel
	output logic      DECISION_STROBE,
	output logic      PHASE_ONE_PULSE,
	output logic      PHASE_TWO_PULSE,
	output logic      PHASE_THREE_PULSE,
	output logic      PHASE_FOUR_PULSE,
	output logic      PHASE_FIVE_PULSE,
	output logic      PHASE_SIX_PULSE,
	output logic      PHASE_SIX_INVERTED,
	output logic      COMPANDER_CTRL,
	output logic      COMPANDER_CTRL_N
);
	cpt_pkg::cpt_state_t s_q;
	cpt_pkg::cpt_state_t s_d;
	logic                clk_edge;
	logic                gated_frame;

	// rising edge of synchronised coder clock
	assign clk_edge = s_q.clk_sync[1] & ~s_q.clk_prev;
	// frame strobe and coder clock coincide
	assign gated_frame = s_q.frame_sync[1] & clk_edge;

	always_comb begin
		s_d = s_q;
		s_d.clk_sync    = {s_q.clk_sync[0], CODER_CLK};
		s_d.frame_sync  = {s_q.frame_sync[0], FRAME_PHASE_STROBE};
		s_d.creset_sync = {s_q.creset_sync[0], COMPANDER_RESET};
		s_d.clk_prev    = s_q.clk_sync[1];
		s_d.dly = {s_q.dly[cpt_pkg::DEC_DELAY_CYC-2:0], s_q.clk_sync[1]};
		s_d.dec = ~s_q.dly[cpt_pkg::DEC_DELAY_CYC-1];
		if (clk_edge) begin
			// first stage from gated frame strobe
			s_d.stage[cpt_pkg::ST_PHASE_TWO] = gated_frame;
			// shift chain one place per clock
			// each stage holds one clock period
			s_d.stage[cpt_pkg::STAGES-1:1] = s_q.stage[cpt_pkg::STAGES-2:0];
		end
		s_d.six_inv = ~s_q.stage[cpt_pkg::ST_PHASE_SIX];
		// set amplifier state, wins over reset
		if (~s_q.six_inv) begin
			s_d.comp = 1'h1;
		end else if (s_q.creset_sync[1] & clk_edge) begin
			s_d.comp = 1'h0;
		end
		s_d.comp_n = ~s_d.comp;
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			s_q             <= '0;
			s_q.stage       <= cpt_pkg::STAGE_RST;
			s_q.comp        <= cpt_pkg::COMP_RST;
			s_q.comp_n      <= ~cpt_pkg::COMP_RST;
			s_q.dec         <= cpt_pkg::DEC_RST;
			s_q.six_inv     <= cpt_pkg::SIX_INV_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign DECISION_STROBE    = s_q.dec;
	assign PHASE_TWO_PULSE    = s_q.stage[cpt_pkg::ST_PHASE_TWO];
	assign PHASE_THREE_PULSE  = s_q.stage[cpt_pkg::ST_PHASE_THREE];
	assign PHASE_FOUR_PULSE   = s_q.stage[cpt_pkg::ST_PHASE_FOUR];
	assign PHASE_FIVE_PULSE   = s_q.stage[cpt_pkg::ST_PHASE_FIVE];
	assign PHASE_SIX_PULSE    = s_q.stage[cpt_pkg::ST_PHASE_SIX];
	assign PHASE_ONE_PULSE    = s_q.stage[cpt_pkg::ST_PHASE_ONE];
	assign PHASE_SIX_INVERTED = s_q.six_inv;
	assign COMPANDER_CTRL     = s_q.comp;
	assign COMPANDER_CTRL_N   = s_q.comp_n;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	sequence s_frame_hit;
		clk_edge && s_q.frame_sync[1];
	endsequence

	sequence s_phase_two_rise;
		##1 PHASE_TWO_PULSE;
	endsequence

	a_dec_delay: assert property (
		##7 (DECISION_STROBE == !$past(s_q.clk_sync[1], 6)))
		else $error("decision strobe not delayed inverted clock");

	a_chain_start: assert property (
		s_frame_hit |-> s_phase_two_rise)
		else $error("phase two did not start on frame strobe");

	a_stage_hold: assert property (
		!clk_edge |=> $stable(s_q.stage))
		else $error("chain changed without coder clock");

	a_phase_three: assert property (
		clk_edge && PHASE_TWO_PULSE |=> PHASE_THREE_PULSE)
		else $error("phase three did not follow phase two");

	a_walk_to_one: assert property (
		clk_edge && PHASE_SIX_PULSE |=> PHASE_ONE_PULSE)
		else $error("phase one did not follow phase six");

	a_six_inverted: assert property (
		PHASE_SIX_PULSE |=> !PHASE_SIX_INVERTED)
		else $error("phase six inverted copy missing");

	a_comp_set: assert property (
		PHASE_SIX_PULSE |-> ##2 COMPANDER_CTRL)
		else $error("compander not set at cycle start");

	a_comp_reset: assert property (
		clk_edge && s_q.creset_sync[1] && PHASE_SIX_INVERTED |=> !COMPANDER_CTRL)
		else $error("compander reset ignored");

	a_walk_four: assert property (
		clk_edge && PHASE_THREE_PULSE |=> PHASE_FOUR_PULSE)
		else $error("phase four did not follow phase three");

	a_walk_five: assert property (
		clk_edge && PHASE_FOUR_PULSE |=> PHASE_FIVE_PULSE)
		else $error("phase five did not follow phase four");

	a_walk_six: assert property (
		clk_edge && PHASE_FIVE_PULSE |=> PHASE_SIX_PULSE)
		else $error("phase six did not follow phase five");

	a_gate_strobe: assert property (
		clk_edge && !s_q.frame_sync[1] |=> !PHASE_TWO_PULSE)
		else $error("phase two started without frame strobe");

	a_one_clear: assert property (
		clk_edge && !PHASE_SIX_PULSE |=> !PHASE_ONE_PULSE)
		else $error("phase one held past one coder period");

	a_three_clear: assert property (
		clk_edge && !PHASE_TWO_PULSE |=> !PHASE_THREE_PULSE)
		else $error("phase three without phase two");

	a_four_clear: assert property (
		clk_edge && !PHASE_THREE_PULSE |=> !PHASE_FOUR_PULSE)
		else $error("phase four without phase three");

	a_five_clear: assert property (
		clk_edge && !PHASE_FOUR_PULSE |=> !PHASE_FIVE_PULSE)
		else $error("phase five without phase four");

	a_six_clear: assert property (
		clk_edge && !PHASE_FIVE_PULSE |=> !PHASE_SIX_PULSE)
		else $error("phase six without phase five");

	a_six_inv_idle: assert property (
		!PHASE_SIX_PULSE |=> PHASE_SIX_INVERTED)
		else $error("phase six inverted low without phase six");

	a_set_wins: assert property (
		!PHASE_SIX_INVERTED |=> COMPANDER_CTRL)
		else $error("compander not set by inverted phase six");

	a_comp_hold: assert property (
		!clk_edge && PHASE_SIX_INVERTED |=> $stable(COMPANDER_CTRL))
		else $error("compander changed without coder clock");

	a_comp_keep: assert property (
		clk_edge && !s_q.creset_sync[1] && PHASE_SIX_INVERTED |=> $stable(COMPANDER_CTRL))
		else $error("compander changed without reset input");

	a_reset_state: assert property (
		$fell(RST) |-> !PHASE_ONE_PULSE && !PHASE_TWO_PULSE && !PHASE_THREE_PULSE
			&& !PHASE_FOUR_PULSE && !PHASE_FIVE_PULSE && !PHASE_SIX_PULSE
			&& COMPANDER_CTRL)
		else $error("state after reset not idle");

	a_comp_pair: assert property (
		COMPANDER_CTRL != COMPANDER_CTRL_N)
		else $error("compander outputs not complementary");
endmodule : cpt_timing_gen

// ### tb_top.sv
// testbench for the coder phase timing generator
`timescale 1ns/100ps
module tb_top;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        frame_req = 1'b0;
	logic        creset_req = 1'b0;
	logic        cclk, fstb, cres, dec, t6n, cc, ccn;
	logic [5:0]  ph;
	logic [10:0] hist = 11'h000;
	int          bad_count = 0;
	int          cmp_count = 0;

	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) hist <= {hist[9:0], cclk};

	cpt_panel_model pm (.clk(ref_clk), .frame_req(frame_req), .creset_req(creset_req),
		.coder_clk(cclk), .frame_stb(fstb), .creset(cres));
	cpt_timing_gen uut (.REF_CLK(ref_clk), .RST(rst), .CODER_CLK(cclk),
		.FRAME_PHASE_STROBE(fstb), .COMPANDER_RESET(cres), .DECISION_STROBE(dec),
		.PHASE_ONE_PULSE(ph[5]), .PHASE_TWO_PULSE(ph[0]), .PHASE_THREE_PULSE(ph[1]),
		.PHASE_FOUR_PULSE(ph[2]), .PHASE_FIVE_PULSE(ph[3]), .PHASE_SIX_PULSE(ph[4]),
		.PHASE_SIX_INVERTED(t6n), .COMPANDER_CTRL(cc), .COMPANDER_CTRL_N(ccn));

	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wait_ph(input int i, output int n);
		n = 0;
		while (ph[i] !== 1'b1 && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
	endtask : wait_ph

	task automatic t_comp;
		int n = 0;
		@(posedge ref_clk) creset_req <= 1'b1;
		while (cc !== 1'b0 && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		chk(10'(n < 40), 10'h001);
		chk(10'(ccn), 10'h001);
		@(posedge ref_clk) creset_req <= 1'b0;
		repeat (50) @(posedge ref_clk);
	endtask : t_comp

	task automatic t_chain;
		int n;
		@(posedge ref_clk) frame_req <= 1'b1;
		repeat (22) @(posedge ref_clk);
		frame_req <= 1'b0;
		wait_ph(0, n);
		chk(10'(n < 200), 10'h001);
		for (int i = 1; i < 6; i++) begin
			wait_ph(i, n);
			chk(10'(n), (i == 5) ? 10'h014 : 10'h016);
			chk(10'(ph), 10'(1 << i));
			if (i == 4) begin
				@(negedge ref_clk);
				chk(10'(t6n), 10'h000);
				@(negedge ref_clk);
				chk({8'h00, cc, ccn}, 10'h002);
			end
		end
	endtask : t_chain

	task automatic t_dec;
		repeat (80) begin
			@(negedge ref_clk);
			chk(10'(dec), 10'(!hist[cpt_pkg::DEC_DELAY_CYC + 2]));
		end
	endtask : t_dec

	task automatic close_out;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out

	initial begin
		repeat (10) @(posedge ref_clk);
		chk({ph, t6n, dec, cc, ccn}, 10'h00E);
		rst <= 1'b0;
		t_comp();
		t_chain();
		t_dec();
		close_out();
	end

	initial begin
		#200000;
		bad_count++;
		close_out();
	end
endmodule : tb_top
